// file: serial_port_pkg.sv
// Constants shared by the serial port control block and its bit-rate generator
package serial_port_pkg;
   localparam int          ADR_W          = 11;
   localparam int          DIV_W          = 13;
   // Register indexes; byte address is four times the index
   localparam logic [8:0]  IDX_BAUD_HI    = 9'h070;
   localparam logic [8:0]  IDX_BAUD_LO    = 9'h071;
   localparam logic [8:0]  IDX_FRAME_CTL  = 9'h072;
   localparam logic [8:0]  IDX_FUNC_CTL   = 9'h073;
   localparam logic [8:0]  IDX_STATUS_ONE = 9'h074;
   localparam logic [8:0]  IDX_STATUS_TWO = 9'h075;
   localparam logic [8:0]  IDX_DATA_HI    = 9'h076;
   localparam logic [8:0]  IDX_DATA_LO    = 9'h077;
   // Values after reset
   localparam logic [7:0]  RST_BAUD_HI    = 8'h00;
   localparam logic [7:0]  RST_BAUD_LO    = 8'h04;
   localparam logic [7:0]  RST_FRAME_CTL  = 8'h00;
   localparam logic [7:0]  RST_FUNC_CTL   = 8'h00;
   localparam logic [7:0]  RST_STATUS_ONE = 8'hC0;
   localparam logic [7:0]  FRAME_CTL_MASK = 8'hDF;
   // frame_control fields
   localparam int          FC_LOOP        = 7;
   localparam int          FC_ODRAIN      = 6;
   localparam int          FC_NINE        = 4;
   localparam int          FC_WAKE        = 3;
   localparam int          FC_ILT         = 2;
   localparam int          FC_PAR         = 1;
   localparam int          FC_ODD         = 0;
   // function_control fields
   localparam int          FN_TIE         = 7;
   localparam int          FN_TX_DONE_IRQ_EN        = 6;
   localparam int          FN_RIE         = 5;
   localparam int          FN_QIE         = 4;
   localparam int          FN_TXON        = 3;
   localparam int          FN_RXON        = 2;
   localparam int          FN_SLEEP       = 1;
   localparam int          FN_BRK         = 0;
   // Field position of the T8 bit in data_buffer high
   localparam int          DH_T8          = 6;
   // Oversampling and frame lengths
   localparam logic [3:0]  OS_LAST        = 4'hF;
   localparam logic [3:0]  SMP_A          = 4'h7;
   localparam logic [3:0]  SMP_B          = 4'h8;
   localparam logic [3:0]  SMP_C          = 4'h9;
   localparam logic [3:0]  FRAME_BITS_8   = 4'hA;
   localparam logic [3:0]  FRAME_BITS_9   = 4'hB;
endpackage : serial_port_pkg

// file: serial_baud_gen.sv
// Bit-rate generator: one 16x oversample enable pulse every 2*divisor clocks
`timescale 1ns/100ps
`default_nettype none
module serial_baud_gen #(
   parameter int DIV_W = serial_port_pkg::DIV_W
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_resetn,
   input  wire logic [DIV_W-1:0] i_divisor,
   input  wire logic             i_run,
   output logic                  o_tick
);
   import serial_port_pkg::*;

   typedef struct packed {
      logic [DIV_W:0] cnt;
      logic           tick;
   } gen_state_t;

   gen_state_t q;
   gen_state_t n;
   logic [DIV_W:0] last;

   assign last = {i_divisor, 1'b0} - {{DIV_W{1'b0}}, 1'b1};

   always_comb begin
      n = q;
      n.tick = 1'b0;
      if (!i_run || i_divisor == '0) begin
         n.cnt = '0;
      end else if (q.cnt >= last) begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_tick = q.tick;

   gen_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (!i_run || i_divisor == '0) |=> !o_tick)
      else $error("bit-rate tick while generator stopped");
   tick_space_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (o_tick && i_divisor == 13'h0001 && $stable(i_divisor) && i_run) |=> !o_tick)
      else $error("bit-rate ticks closer than twice the divisor");
endmodule : serial_baud_gen
`default_nettype wire

// file: serial_port_ctrl.sv
// Asynchronous serial port: registers, transmitter, receiver, wake-up and idle logic
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Bit rate is clock over 32 times divisor
// - Generator stops on zero divisor or both off
// - Divisor takes effect on low byte write
// - Loopback feeds transmitter to receiver, pin high
// - Open-drain pin driving when selected
// - Nine or eight data bits per frame
// - Wake on address mark or idle line
// - Idle counting after stop or after start
// - Parity generated and checked, odd or even
// - Transmit empty and done interrupt requests
// - Receive, overrun and idle interrupt requests
// - Transmitter starts frames and receiver runs only when enabled
// - Sleep arms wake-up, blocks receive interrupts
// - Break frames sent while break control set
// - Buffer empty flag, cleared status-read then write
// - Done flag, cleared status-read then write only while transmitter busy
// - Buffer full flag, cleared status-read then read
// - Quiet flag once per activity, not sleeping
// - Overrun when buffer still full on arrival
// - Noise when majority samples disagree
// - Framing error on zero stop bit
// - Parity error on wrong received parity
// - Start low, data LSB first, stop high
// - Overrun hides framing error, keeps old data
module serial_port_ctrl (
   input  wire logic                              i_core_clk,
   input  wire logic                              i_resetn,
   input  wire logic                              i_wb_cyc,
   input  wire logic                              i_wb_stb,
   input  wire logic                              i_wb_we,
   input  wire logic [serial_port_pkg::ADR_W-1:0] i_wb_adr,
   input  wire logic [31:0]                       i_wb_dat,
   input  wire logic [3:0]                        i_wb_sel,
   output logic      [31:0]                       o_wb_dat,
   output logic                                   o_wb_ack,
   input  wire logic                              i_rxd,
   output logic                                   o_txd_out,
   output logic                                   o_txd_oe_n,
   output logic                                   o_irq
);
   import serial_port_pkg::*;

   typedef enum logic {TX_IDLE, TX_SHIFT} tx_st_t;
   typedef enum logic {RX_IDLE, RX_FRAME} rx_st_t;

   typedef struct packed {
      logic             ack;
      logic [7:0]       rdat;
      logic [7:0]       bd_hi;
      logic [7:0]       bd_lo;
      logic [DIV_W-1:0] div_eff;
      logic [7:0]       fctl;
      logic [7:0]       fnc;
      logic [7:0]       stat;
      logic [7:0]       arm;
      logic [8:0]       tbuf;
      tx_st_t           tx_st;
      logic [10:0]      tsh;
      logic [3:0]       tcnt;
      logic [3:0]       tph;
      logic             tx_on_d;
      logic             pre;
      logic             txd_int;
      logic             pin_out;
      logic             pin_oen;
      logic             rx_s1;
      logic             rx_s2;
      rx_st_t           rx_st;
      logic [3:0]       rph;
      logic [3:0]       rbits;
      logic [2:0]       smp;
      logic [8:0]       rsh;
      logic             rnoise;
      logic [8:0]       rdata;
      logic [3:0]       isub;
      logic [3:0]       icnt;
      logic             line_act;
   } port_state_t;

   port_state_t q;
   port_state_t n;
   logic        tick;
   logic        run;
   logic        acc;
   logic        wr;
   logic        rd;
   logic [8:0]  idx;

   // Build the serial frame, LSB first, parity taking the top data bit
   function automatic logic [10:0] tx_frame(input logic [8:0] d, input logic nine,
                                            input logic par, input logic odd);
      logic [8:0] v;
      v = d;
      if (par && nine) begin
         v[8] = (^d[7:0]) ^ odd;
      end else if (par) begin
         v[7] = (^d[6:0]) ^ odd;
      end
      tx_frame = nine ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
   endfunction : tx_frame

   function automatic logic [3:0] frame_bits(input logic nine);
      frame_bits = nine ? FRAME_BITS_9 : FRAME_BITS_8;
   endfunction : frame_bits

   assign acc = i_wb_cyc & i_wb_stb & ~q.ack;
   assign wr  = acc & i_wb_we & i_wb_sel[0];
   assign rd  = acc & ~i_wb_we;
   assign idx = i_wb_adr[ADR_W-1:2];
   assign run = q.fnc[FN_TXON] | q.fnc[FN_RXON];

   serial_baud_gen #(
      .DIV_W (DIV_W)
   ) u_baud (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_divisor  (q.div_eff),
      .i_run      (run),
      .o_tick     (tick)
   );

   always_comb begin
      logic       nine;
      logic       tx_on;
      logic       rx_on;
      logic       brk;
      logic       loop;
      logic       rxin;
      logic       maj;
      logic       msb;
      logic       val;
      logic       drv;
      logic [8:0] d;
      nine  = q.fctl[FC_NINE];
      tx_on = q.fnc[FN_TXON];
      rx_on = q.fnc[FN_RXON];
      brk   = q.fnc[FN_BRK];
      loop  = q.fctl[FC_LOOP];
      rxin  = loop ? q.txd_int : q.rx_s2;
      maj   = 1'b0;
      msb   = 1'b0;
      val   = 1'b1;
      drv   = 1'b0;
      d     = '0;
      n     = q;
      n.ack = acc;
      n.rx_s1 = i_rxd;
      n.rx_s2 = q.rx_s1;

      // Register bus; clears come first so hardware sets below win
      if (rd) begin
         unique case (idx)
            IDX_BAUD_HI:    n.rdat = q.bd_hi;
            IDX_BAUD_LO:    n.rdat = q.bd_lo;
            IDX_FRAME_CTL:  n.rdat = q.fctl;
            IDX_FUNC_CTL:   n.rdat = q.fnc;
            IDX_STATUS_ONE: begin
               n.rdat = q.stat;
               n.arm  = q.stat;
            end
            IDX_STATUS_TWO: n.rdat = {7'h00, q.rx_st == RX_FRAME};
            IDX_DATA_HI:    n.rdat = {q.rdata[8], q.tbuf[8], 6'h00};
            IDX_DATA_LO:    begin
               n.rdat      = q.rdata[7:0];
               n.stat[5:0] = q.stat[5:0] & ~q.arm[5:0];
               n.arm[5:0]  = 6'h00;
            end
            default:        n.rdat = 8'h00;
         endcase
      end
      if (wr) begin
         unique case (idx)
            IDX_BAUD_HI:   n.bd_hi = i_wb_dat[7:0];
            IDX_BAUD_LO:   begin
               n.bd_lo   = i_wb_dat[7:0];
               n.div_eff = {q.bd_hi[DIV_W-9:0], i_wb_dat[7:0]};
            end
            IDX_FRAME_CTL: n.fctl = i_wb_dat[7:0] & FRAME_CTL_MASK;
            IDX_FUNC_CTL:  n.fnc = i_wb_dat[7:0];
            IDX_DATA_HI:   n.tbuf[8] = i_wb_dat[DH_T8];
            IDX_DATA_LO:   begin
               n.tbuf[7:0] = i_wb_dat[7:0];
               n.stat[7:6] = q.stat[7:6] & ~q.arm[7:6];
               n.arm[7:6]  = 2'b00;
            end
            default:       ;
         endcase
      end

      // Transmitter
      n.tx_on_d = tx_on;
      if (tx_on && !q.tx_on_d) begin
         n.pre = 1'b1;
      end
      if (!run) begin
         n.tx_st = TX_IDLE;
      end else if (tick) begin
         unique case (q.tx_st)
            TX_IDLE: begin
               n.tph  = 4'h0;
               n.tcnt = frame_bits(nine);
               if (tx_on && q.pre) begin
                  n.tsh   = '1;
                  n.pre   = 1'b0;
                  n.tx_st = TX_SHIFT;
               end else if (tx_on && brk) begin
                  n.tsh   = '0;
                  n.tx_st = TX_SHIFT;
               end else if (tx_on && !q.stat[7]) begin
                  n.tsh     = tx_frame(q.tbuf, nine, q.fctl[FC_PAR], q.fctl[FC_ODD]);
                  n.stat[7] = 1'b1;
                  n.tx_st   = TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               n.tph = q.tph + 4'h1;
               if (q.tph == OS_LAST) begin
                  n.tsh  = {1'b1, q.tsh[10:1]};
                  n.tcnt = q.tcnt - 4'h1;
                  if (q.tcnt == 4'h1) begin
                     n.tx_st = TX_IDLE;
                  end
               end
            end
         endcase
      end
      if (q.tx_st == TX_IDLE && q.stat[7] && !brk && !q.pre) begin
         n.stat[6] = 1'b1;
      end
      // Idle line stays low between back-to-back break frames
      n.txd_int = (n.tx_st == TX_SHIFT) ? n.tsh[0] : ~(brk & tx_on);
      val       = loop ? 1'b1 : n.txd_int;
      drv       = n.fnc[FN_TXON] | (n.tx_st == TX_SHIFT);
      n.pin_out = val;
      n.pin_oen = ~(drv & (~n.fctl[FC_ODRAIN] | ~val));

      // Receiver, 16x oversampled with three-sample majority
      if (!rx_on || !run) begin
         n.rx_st = RX_IDLE;
         n.icnt  = 4'h0;
      end else if (tick) begin
         n.isub = q.isub + 4'h1;
         if (q.isub == OS_LAST) begin
            if (!rxin || (q.fctl[FC_ILT] && q.rx_st == RX_FRAME)) begin
               n.icnt = 4'h0;
            end else if (q.icnt != frame_bits(nine)) begin
               n.icnt = q.icnt + 4'h1;
            end
            if (q.icnt + 4'h1 == frame_bits(nine) && rxin && q.line_act) begin
               n.line_act = 1'b0;
               if (q.fnc[FN_SLEEP] && !q.fctl[FC_WAKE]) begin
                  n.fnc[FN_SLEEP] = 1'b0;
               end
               if (!q.fnc[FN_SLEEP]) begin
                  n.stat[4] = 1'b1;
               end
            end
         end
         unique case (q.rx_st)
            RX_IDLE: begin
               if (!rxin) begin
                  n.rx_st    = RX_FRAME;
                  n.rph      = 4'h0;
                  n.rbits    = 4'h0;
                  n.rnoise   = 1'b0;
                  n.line_act = 1'b1;
               end
            end
            RX_FRAME: begin
               n.rph = q.rph + 4'h1;
               if (q.rph == SMP_A) n.smp[0] = rxin;
               if (q.rph == SMP_B) n.smp[1] = rxin;
               if (q.rph == SMP_C) n.smp[2] = rxin;
               if (q.rph == OS_LAST) begin
                  maj      = (q.smp[0] & q.smp[1]) | (q.smp[0] & q.smp[2]) |
                             (q.smp[1] & q.smp[2]);
                  n.rnoise = q.rnoise | ~((&q.smp) | ~(|q.smp));
                  n.rbits  = q.rbits + 4'h1;
                  if (q.rbits == 4'h0 && maj) begin
                     n.rx_st = RX_IDLE;
                  end else if (q.rbits + 4'h1 != frame_bits(nine)) begin
                     if (q.rbits != 4'h0) n.rsh = {maj, q.rsh[8:1]};
                  end else begin
                     n.rx_st = RX_IDLE;
                     d   = nine ? q.rsh : {1'b0, q.rsh[8:1]};
                     msb = nine ? d[8] : d[7];
                     if (q.fnc[FN_SLEEP] && q.fctl[FC_WAKE] && msb) begin
                        n.fnc[FN_SLEEP] = 1'b0;
                     end
                     if (!q.fnc[FN_SLEEP] || (q.fctl[FC_WAKE] && msb)) begin
                        if (q.stat[5] || q.stat[1]) begin
                           n.stat[3] = 1'b1;
                        end else begin
                           n.rdata   = d;
                           n.stat[5] = 1'b1;
                           n.stat[2] = n.rnoise;
                           n.stat[1] = ~maj;
                           n.stat[0] = q.fctl[FC_PAR] &
                                       ((nine ? ^d : ^d[7:0]) ^ q.fctl[FC_ODD]);
                        end
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q         <= '0;
         q.bd_hi   <= RST_BAUD_HI;
         q.bd_lo   <= RST_BAUD_LO;
         q.div_eff <= {RST_BAUD_HI[DIV_W-9:0], RST_BAUD_LO};
         q.fctl    <= RST_FRAME_CTL;
         q.fnc     <= RST_FUNC_CTL;
         q.stat    <= RST_STATUS_ONE;
         q.txd_int <= 1'b1;
         q.pin_out <= 1'b1;
         q.pin_oen <= 1'b1;
         q.rx_s1   <= 1'b1;
         q.rx_s2   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign o_wb_dat   = {24'h000000, q.rdat};
   assign o_wb_ack   = q.ack;
   assign o_txd_out  = q.pin_out;
   assign o_txd_oe_n = q.pin_oen;
   // Receive sources are gated in sleep so a stale flag cannot wake the CPU
   assign o_irq = (q.fnc[FN_TIE] & q.stat[7]) | (q.fnc[FN_TX_DONE_IRQ_EN] & q.stat[6]) |
                  (~q.fnc[FN_SLEEP] & q.fnc[FN_RIE] & (q.stat[5] | q.stat[3])) |
                  (~q.fnc[FN_SLEEP] & q.fnc[FN_QIE] & q.stat[4]);

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   ack_drop_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held for two cycles");
   div_commit_a: assert property (wr && idx == IDX_BAUD_HI |=> $stable(q.div_eff))
      else $error("divisor changed on high byte write");
   loop_pin_a: assert property (q.fctl[FC_LOOP] && q.fnc[FN_TXON] && !q.fctl[FC_ODRAIN]
      |=> o_txd_out && !o_txd_oe_n)
      else $error("loopback pin not driven high");
   odrain_high_a: assert property (q.fctl[FC_ODRAIN] && o_txd_out |-> o_txd_oe_n)
      else $error("open-drain pin drives high");
   tx_irq_a: assert property (q.fnc[FN_TIE] && q.stat[7] |-> o_irq)
      else $error("buffer empty interrupt missing");
   sleep_irq_a: assert property (q.fnc[FN_SLEEP] && !q.fnc[FN_TIE] && !q.fnc[FN_TX_DONE_IRQ_EN]
      |-> !o_irq)
      else $error("receive interrupt while sleeping");
   quiet_sleep_a: assert property (q.fnc[FN_SLEEP] && !q.stat[4] |=> !q.stat[4])
      else $error("quiet flag set while sleeping");
   overrun_keep_a: assert property (q.stat[5] && !(rd && idx == IDX_DATA_LO)
      |=> $stable(q.rdata))
      else $error("buffered character overwritten");
   brk_low_a: assert property (q.tx_st == TX_SHIFT && q.fnc[FN_BRK] && q.tsh == '0
      |-> !q.txd_int)
      else $error("break frame not low");
endmodule : serial_port_ctrl
`default_nettype wire

// file: remote_serial_node.sv
// Remote serial node: drives the receive pin and decodes the transmit pin
`timescale 1ns/100ps
`default_nettype none
module remote_serial_node #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic i_core_clk,
   input  wire logic i_line,
   output logic      o_rxd
);
   initial o_rxd = 1'b1;
   // Caller picks the stop level so a framing fault can be forced
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] fr;
      fr = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rxd <= fr[i];
         repeat (BIT_CLKS) @(posedge i_core_clk);
      end
      // One idle clock so a following frame never lands in the same step
      o_rxd <= 1'b1;
      @(posedge i_core_clk);
   endtask : send
   // Fixed mid-bit sampling, so a wrong bit rate shows as bad data
   task automatic recv(output logic [7:0] b, output logic stop);
      int n;
      n = 0;
      while (i_line !== 1'b0 && n < 20000) begin
         @(posedge i_core_clk);
         n++;
      end
      repeat (BIT_CLKS / 2) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge i_core_clk);
         b[i] = i_line;
      end
      repeat (BIT_CLKS) @(posedge i_core_clk);
      stop = i_line;
   endtask : recv
endmodule : remote_serial_node
`default_nettype wire

// file: tb_top.sv
// Register-level testbench for the serial port control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import serial_port_pkg::*;
   logic             i_core_clk;
   logic             i_resetn;
   logic             cyc, stb, we;
   logic [ADR_W-1:0] adr;
   logic [31:0]      wdat, rdat;
   logic [3:0]       sel;
   logic             ack, rxd, txd_out, txd_oe_n, irq, txd_line, stop_bit, loop_mon;
   logic [7:0]       v;
   int               fails, cmp_count, cycles, pin_low;
   logic [8:0]       idx_t [5] = '{IDX_BAUD_HI, IDX_BAUD_LO, IDX_FRAME_CTL, IDX_FUNC_CTL,
                                   IDX_STATUS_ONE};
   logic [7:0]       rst_t [5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hC0};
   // Released pin floats to its pull-up
   assign txd_line = txd_oe_n ? 1'b1 : txd_out;
   serial_port_ctrl i_serial_port_ctrl (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
      .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rxd(rxd), .o_txd_out(txd_out),
      .o_txd_oe_n(txd_oe_n), .o_irq(irq));
   remote_serial_node #(.BIT_CLKS(32)) i_remote_serial_node (.i_core_clk(i_core_clk),
      .i_line(txd_line), .o_rxd(rxd));
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (loop_mon && txd_line !== 1'b1) pin_low <= pin_low + 1;
      if (cycles == 30000) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
      int n;
      @(posedge i_core_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      sel  <= 4'hF;
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) fails++;
   endtask : wb
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      logic [7:0] r;
      wb(1'b1, idx, d, r);
   endtask : wr
   task automatic rd(input logic [8:0] idx);
      wb(1'b0, idx, 8'h00, v);
   endtask : rd
   task automatic poll(input logic [7:0] m);
      int n;
      n = 0;
      rd(IDX_STATUS_ONE);
      while ((v & m) !== m && n < 400) begin
         rd(IDX_STATUS_ONE);
         n++;
      end
      chk("status_poll", v & m, m);
   endtask : poll
   initial begin
      {cyc, stb, we, sel, adr, wdat, loop_mon} = '0;
      {fails, cmp_count, cycles, pin_low} = '0;
      i_resetn = 1'b0;
      repeat (6) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(idx_t[i]);
         chk("reset_value", v, rst_t[i]);
      end
      rd(9'h07F);
      chk("unmapped", v, 8'h00);
      $display("test reset done");
      wr(IDX_BAUD_HI, 8'h00);
      wr(IDX_BAUD_LO, 8'h01);
      wr(IDX_FUNC_CTL, 8'h0C);
      rd(IDX_STATUS_ONE);
      wr(IDX_DATA_LO, 8'hA5);
      rd(IDX_STATUS_ONE);
      chk("tx_flags_clear", v & 8'hC0, 8'h00);
      i_remote_serial_node.recv(v, stop_bit);
      chk("tx_byte", v, 8'hA5);
      chk("tx_stop", {7'h00, stop_bit}, 8'h01);
      poll(8'hC0);
      wr(IDX_FUNC_CTL, 8'h8C);
      chk("irq_tx_empty", {7'h00, irq}, 8'h01);
      wr(IDX_FUNC_CTL, 8'h4C);
      chk("irq_tx_done", {7'h00, irq}, 8'h01);
      wr(IDX_FUNC_CTL, 8'h2C);
      chk("irq_masked", {7'h00, irq}, 8'h00);
      $display("test transmit done");
      i_remote_serial_node.send(8'h3C, 1'b1);
      poll(8'h20);
      chk("irq_rx", {7'h00, irq}, 8'h01);
      rd(IDX_DATA_LO);
      chk("rx_byte", v, 8'h3C);
      rd(IDX_STATUS_ONE);
      chk("rx_full_clear", v & 8'h20, 8'h00);
      chk("irq_rx_clear", {7'h00, irq}, 8'h00);
      poll(8'h10);
      rd(IDX_DATA_LO);
      // Two frame lengths of idle line
      repeat (640) @(posedge i_core_clk);
      rd(IDX_STATUS_ONE);
      chk("quiet_once", v & 8'h10, 8'h00);
      $display("test receive done");
      i_remote_serial_node.send(8'h11, 1'b1);
      // Bad stop on the overrunning frame: only the overrun may show
      i_remote_serial_node.send(8'h22, 1'b0);
      poll(8'h28);
      chk("overrun_no_fe", v & 8'h02, 8'h00);
      rd(IDX_DATA_LO);
      chk("overrun_keeps", v, 8'h11);
      rd(IDX_STATUS_ONE);
      chk("overrun_clear", v & 8'h2F, 8'h00);
      i_remote_serial_node.send(8'h55, 1'b0);
      poll(8'h22);
      rd(IDX_DATA_LO);
      rd(IDX_STATUS_ONE);
      chk("frame_err_clear", v & 8'h02, 8'h00);
      $display("test errors done");
      for (int p = 0; p < 2; p++) begin
         wr(IDX_FRAME_CTL, 8'h02 | 8'(p));
         i_remote_serial_node.send(8'h01, 1'b1);
         poll(8'h20);
         chk("parity_err", v & 8'h01, (p == 0) ? 8'h01 : 8'h00);
         rd(IDX_DATA_LO);
      end
      $display("test parity done");
      // Address-mark wake: unmarked frame is dropped, marked one wakes
      wr(IDX_FRAME_CTL, 8'h08);
      wr(IDX_FUNC_CTL, 8'h2E);
      i_remote_serial_node.send(8'h01, 1'b1);
      repeat (40) @(posedge i_core_clk);
      rd(IDX_STATUS_ONE);
      chk("sleep_drop", v & 8'h28, 8'h00);
      i_remote_serial_node.send(8'h81, 1'b1);
      poll(8'h20);
      rd(IDX_DATA_LO);
      chk("wake_byte", v, 8'h81);
      rd(IDX_FUNC_CTL);
      chk("wake_clears", v, 8'h2C);
      $display("test wake done");
      wr(IDX_FRAME_CTL, 8'h90);
      loop_mon <= 1'b1;
      rd(IDX_STATUS_ONE);
      wr(IDX_DATA_HI, 8'h40);
      wr(IDX_DATA_LO, 8'h5A);
      poll(8'h20);
      rd(IDX_DATA_HI);
      chk("loop_ninth", v, 8'hC0);
      rd(IDX_DATA_LO);
      chk("loop_byte", v, 8'h5A);
      chk("loop_pin_high", 8'(pin_low), 8'h00);
      wr(IDX_FRAME_CTL, 8'h00);
      wr(IDX_FUNC_CTL, 8'h00);
      rd(IDX_STATUS_ONE);
      wr(IDX_DATA_LO, 8'h00);
      repeat (640) @(posedge i_core_clk);
      chk("tx_off_idle", 8'(pin_low), 8'h00);
      wr(IDX_FRAME_CTL, 8'h40);
      wr(IDX_FUNC_CTL, 8'h09);
      // Preamble frame first, then break frames
      repeat (800) @(posedge i_core_clk);
      chk("break_low", {7'h00, txd_line}, 8'h00);
      chk("odrain_drive_low", {7'h00, txd_oe_n}, 8'h00);
      wr(IDX_FUNC_CTL, 8'h08);
      // Break frame ends, then the pending zero byte goes out
      repeat (800) @(posedge i_core_clk);
      chk("break_end", {7'h00, txd_line}, 8'h01);
      chk("odrain_release", {7'h00, txd_oe_n}, 8'h01);
      $display("test loopback, disable and break done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
